// [rtl/crhr_encoder.sv]
/*
 * Crate read-out sequencer: captures station hit patterns, walks every
 * set wire of every flagged station, and offers one word per wire.
 * Assumes module pins and the upstream handshake are asynchronous to
 * CLK; the register port is synchronous to CLK.
 */
`timescale 1ns/1ps
`default_nettype none
module crhr_encoder (
  // Clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // Register port
  input wire logic [3:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  // Chain and upstream handshake
  input wire logic READ_CMD_IN,
  input wire logic EXT_START,
  input wire logic EXT_RESET,
  input wire logic TRANSFER_DONE_FLAG,
  output logic READ_CMD_OUT,
  output logic END_OF_READOUT,
  output logic WORD_READY_STROBE,
  output crhr_pkg::crhr_word_s WORD_OUT,
  output logic BUSY,
  output logic CRATE12_WARN,
  // Station side
  input wire logic [crhr_pkg::N_ST-1:0] MODULE_HIT_ANY,
  input wire logic [crhr_pkg::N_WIRE-1:0] MODULE_DATA,
  input wire logic MODULE_FLAG,
  output logic [crhr_pkg::N_ST-1:0] MODULE_READ_N,
  output logic MODULE_RESET
);
  typedef enum logic [3:0] {
    S_IDLE, S_OVH, S_LATCH_ST, S_DECIDE, S_SELECT, S_LATCH_WP,
    S_OFFER, S_RELEASE, S_CLR_W, S_FORWARD
  } crhr_state_e;

  localparam int NS = crhr_pkg::N_ST;
  localparam int NW = crhr_pkg::N_WIRE;

  crhr_state_e state_q;
  logic [crhr_pkg::CTRL_W-1:0] ctrl_q;
  logic [NS-1:0] st_pat_q;
  logic [crhr_pkg::WP_W-1:0] wp_q;
  logic [crhr_pkg::CNT_W-1:0] cnt_q;
  logic [crhr_pkg::CNT_W-1:0] xfer_q;
  logic [crhr_pkg::ST_AW-1:0] st_idx;
  logic [crhr_pkg::WI_W+1-1:0] wp_idx;
  logic st_any, wp_any;
  logic soft_start, soft_reset;

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [NS-1:0] hit_m, hit_s;
  logic [NW:0] dat_m, dat_s;
  logic [3:0] ctl_m, ctl_s;
  logic cmd_d1, start_d1;

  // Two flops on every pin input
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      hit_m <= '0;
      hit_s <= '0;
      dat_m <= '0;
      dat_s <= '0;
      ctl_m <= '0;
      ctl_s <= '0;
    end else begin
      hit_m <= MODULE_HIT_ANY;
      hit_s <= hit_m;
      dat_m <= {MODULE_FLAG, MODULE_DATA};
      dat_s <= dat_m;
      ctl_m <= {EXT_RESET, TRANSFER_DONE_FLAG, EXT_START, READ_CMD_IN};
      ctl_s <= ctl_m;
    end
  end

  // Edge history for the start inputs
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      cmd_d1 <= 1'b0;
      start_d1 <= 1'b0;
    end else begin
      cmd_d1 <= ctl_s[0];
      start_d1 <= ctl_s[1];
    end
  end

  logic done_s, ext_rst_s, start_req;
  assign done_s = ctl_s[2];
  assign ext_rst_s = ctl_s[3];
  // Read command or external start rising edge, or a start write to the control register
  assign start_req = (ctl_s[0] & ~cmd_d1) | (ctl_s[1] & ~start_d1)
                     | soft_start;

  // ****************************************
  // Register port
  // ****************************************
  assign soft_start = WR && ADDR == crhr_pkg::REG_CTRL
                      && WDATA[crhr_pkg::CTRL_START];
  assign soft_reset = WR && ADDR == crhr_pkg::REG_CTRL
                      && WDATA[crhr_pkg::CTRL_RESET];

  // Switch settings held in the control register
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      ctrl_q <= crhr_pkg::CTRL_RST;
    end else if (WR && ADDR == crhr_pkg::REG_CTRL) begin
      ctrl_q <= WDATA[crhr_pkg::CTRL_W-1:0];
    end
  end

  logic [crhr_pkg::CRATE_W-1:0] crate_sw, crate_eff;
  logic [crhr_pkg::CHAIN_W-1:0] chain_sw;
  assign crate_sw = ctrl_q[crhr_pkg::CTRL_CRATE_LSB +: crhr_pkg::CRATE_W];
  assign chain_sw = ctrl_q[crhr_pkg::CTRL_CHAIN_LSB +: crhr_pkg::CHAIN_W];
  // Position zero becomes crate 12 when selected
  assign crate_eff = (ctrl_q[crhr_pkg::CTRL_X12] && crate_sw == '0)
                     ? crhr_pkg::CRATE_X12 : crate_sw;

  // Read data one cycle after the strobe, zero otherwise
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      RDATA <= '0;
    end else if (RD) begin
      case (ADDR)
        crhr_pkg::REG_CTRL: RDATA <= 32'(ctrl_q);
        crhr_pkg::REG_STAT: RDATA <= 32'({state_q, CRATE12_WARN, BUSY});
        crhr_pkg::REG_PAT: RDATA <= 32'(st_pat_q);
        crhr_pkg::REG_WORD: RDATA <= 32'(WORD_OUT);
        default: RDATA <= '0;
      endcase
    end else begin
      RDATA <= '0;
    end
  end

  // ****************************************
  // Encoders
  // ****************************************
  crhr_prio_enc #(.W(NS), .IW(crhr_pkg::ST_AW)) u_st_enc (
    .pat(st_pat_q),
    .idx(st_idx),
    .any(st_any)
  );

  crhr_prio_enc #(.W(crhr_pkg::WP_W), .IW(crhr_pkg::WI_W + 1)) u_wp_enc (
    .pat(wp_q),
    .idx(wp_idx),
    .any(wp_any)
  );

  // Station number with crate offset
  function automatic logic [crhr_pkg::STN_W-1:0] stn_num(
    input logic [crhr_pkg::CRATE_W-1:0] crate,
    input logic [crhr_pkg::ST_AW-1:0] idx
  );
    logic [2*crhr_pkg::STN_W-1:0] prod;
    prod = crhr_pkg::STN_W'(crate) * crhr_pkg::ST_PER_CRATE;
    return prod[crhr_pkg::STN_W-1:0] + crhr_pkg::STN_W'(idx);
  endfunction

  // ****************************************
  // Sequencer
  // ****************************************
  logic abort;
  assign abort = ext_rst_s | soft_reset;

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      state_q <= S_IDLE;
      cnt_q <= '0;
    end else if (abort) begin
      state_q <= S_IDLE;
      cnt_q <= '0;
    end else begin
      case (state_q)
        S_IDLE: if (start_req) begin
          state_q <= S_OVH;
          cnt_q <= crhr_pkg::CNT_W'(crhr_pkg::OVH_CYC - 1);
        end
        // Fixed crate overhead
        S_OVH: if (cnt_q == '0) begin
          state_q <= S_LATCH_ST;
        end else begin
          cnt_q <= cnt_q - 1'b1;
        end
        S_LATCH_ST: state_q <= S_DECIDE;
        // Nothing flagged forwards at once
        S_DECIDE: if (st_any) begin
          state_q <= S_SELECT;
          cnt_q <= crhr_pkg::CNT_W'(crhr_pkg::SETTLE_CYC);
        end else begin
          state_q <= S_FORWARD;
        end
        // Allow select and data to cross the synchroniser
        S_SELECT: if (cnt_q == '0) begin
          state_q <= S_LATCH_WP;
        end else begin
          cnt_q <= cnt_q - 1'b1;
        end
        S_LATCH_WP: state_q <= S_CLR_W;
        // Word held until the far side answers
        S_OFFER: if (done_s) begin
          state_q <= S_RELEASE;
        end
        // Wait for done to drop and the least word time
        S_RELEASE: if (!done_s && xfer_q == '0) begin
          state_q <= S_CLR_W;
        end
        // Offer next wire or move to next station
        S_CLR_W: if (wp_any) begin
          state_q <= S_OFFER;
        end else begin
          state_q <= S_DECIDE;
        end
        S_FORWARD: state_q <= S_IDLE;
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // Station pattern capture and erase
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      st_pat_q <= '0;
    end else if (state_q == S_LATCH_ST) begin
      st_pat_q <= hit_s;
    end else if (state_q == S_CLR_W && !wp_any) begin
      st_pat_q <= st_pat_q & (st_pat_q - 1'b1);
    end
  end

  // Wire pattern capture and erase
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      wp_q <= '0;
    end else if (state_q == S_LATCH_WP) begin
      wp_q <= dat_s;
    end else if (state_q == S_RELEASE && !done_s && xfer_q == '0) begin
      wp_q <= wp_q & (wp_q - 1'b1);
    end
  end

  // Per-word least transfer time counter
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      xfer_q <= '0;
    end else if (state_q == S_CLR_W && wp_any) begin
      xfer_q <= crhr_pkg::CNT_W'(crhr_pkg::MIN_XFER_CYC - 2);
    end else if (xfer_q != '0) begin
      xfer_q <= xfer_q - 1'b1;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Active-low station select
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      MODULE_READ_N <= '1;
    end else if (state_q == S_DECIDE && st_any && !abort) begin
      MODULE_READ_N <= ~(NS'(1) << st_idx);
    end else if (state_q == S_LATCH_WP || abort) begin
      MODULE_READ_N <= '1;
    end
  end

  // Word build and strobe
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      WORD_OUT <= '0;
      WORD_READY_STROBE <= 1'b0;
    end else if (state_q == S_CLR_W && wp_any && !abort) begin
      WORD_OUT.chain <= chain_sw;
      WORD_OUT.station <= stn_num(crate_eff, st_idx);
      WORD_OUT.flag <= wp_idx[crhr_pkg::WI_W];
      WORD_OUT.raw <= {st_idx, wp_idx[crhr_pkg::WI_W-1:0]};
      WORD_READY_STROBE <= 1'b1;
    end else if (done_s || abort) begin
      WORD_READY_STROBE <= 1'b0;
    end
  end

  // Command onward or back upstream
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      READ_CMD_OUT <= 1'b0;
      END_OF_READOUT <= 1'b0;
    end else begin
      READ_CMD_OUT <= state_q == S_FORWARD && !ctrl_q[crhr_pkg::CTRL_LAST];
      END_OF_READOUT <= state_q == S_FORWARD && ctrl_q[crhr_pkg::CTRL_LAST];
    end
  end

  // Busy, warning lamp and station reset
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      BUSY <= 1'b0;
      CRATE12_WARN <= 1'b0;
      MODULE_RESET <= 1'b0;
    end else begin
      BUSY <= state_q != S_IDLE && !abort;
      CRATE12_WARN <= ctrl_q[crhr_pkg::CTRL_X12];
      MODULE_RESET <= abort;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  a_station_latch: assert property (
    @(posedge CLK) disable iff (!NRST)
    state_q == S_LATCH_ST && !abort |=> st_pat_q == $past(hit_s))
    else $error("station pattern not latched");

  a_select_lowest: assert property (
    @(posedge CLK) disable iff (!NRST)
    state_q == S_DECIDE && st_any && !abort |=>
      MODULE_READ_N == ~(NS'(1) << $past(st_idx)) && st_pat_q[$past(st_idx)])
    else $error("wrong station selected");

  a_word_concat: assert property (
    @(posedge CLK) disable iff (!NRST)
    $rose(WORD_READY_STROBE) |->
      WORD_OUT.station == stn_num(crate_eff, WORD_OUT.raw[8:4]))
    else $error("station number mismatch");

  a_hold_until_done: assert property (
    @(posedge CLK) disable iff (!NRST)
    WORD_READY_STROBE && !done_s && !abort |=> WORD_READY_STROBE)
    else $error("word withdrawn before done");

  a_wire_clear: assert property (
    @(posedge CLK) disable iff (!NRST)
    $changed(wp_q) |-> $past(state_q) inside {S_LATCH_WP, S_RELEASE})
    else $error("wire pattern changed without done");

  a_min_word: assert property (
    @(posedge CLK) disable iff (!NRST)
    $rose(WORD_READY_STROBE) |-> !(state_q == S_CLR_W) [*8])
    else $error("word time below minimum");

  a_overhead: assert property (
    @(posedge CLK) disable iff (!NRST)
    state_q == S_IDLE && start_req && !abort |=>
      (state_q == S_OVH) [*8])
    else $error("overhead too short");

  a_empty_forward: assert property (
    @(posedge CLK) disable iff (!NRST)
    state_q == S_DECIDE && !st_any && !abort |=> ##1
      (READ_CMD_OUT || END_OF_READOUT) && !WORD_READY_STROBE)
    else $error("empty crate not forwarded");

  a_crate12_map: assert property (
    @(posedge CLK) disable iff (!NRST)
    ctrl_q[crhr_pkg::CTRL_X12] && crate_sw == '0 |->
      crate_eff == crhr_pkg::CRATE_X12 ##1 CRATE12_WARN)
    else $error("crate twelve not applied");
endmodule
`default_nettype wire

// [rtl/crhr_pkg.sv]
/*
 * Shared constants and types of the crate hit read-out encoder.
 * Assumes a 25 MHz system clock; the overhead and word-time counts are derived from it.
 */
package crhr_pkg;
  // ****************************************
  // Geometry
  // ****************************************
  localparam int N_ST = 22;
  localparam int ST_AW = 5;
  localparam int N_WIRE = 16;
  localparam int WP_W = 17;
  localparam int WI_W = 4;
  localparam int STN_W = 9;
  localparam int CHAIN_W = 3;
  localparam int CRATE_W = 4;
  localparam logic [CRATE_W-1:0] CRATE_X12 = 4'hC;
  localparam logic [STN_W-1:0] ST_PER_CRATE = 9'h016;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_NS = 40;
  localparam int OVH_NS = 1000;
  localparam int MIN_XFER_NS = 600;
  localparam int OVH_CYC = (OVH_NS + CLK_NS - 1) / CLK_NS;
  localparam int MIN_XFER_CYC = (MIN_XFER_NS + CLK_NS - 1) / CLK_NS;
  localparam int SETTLE_CYC = 3;
  localparam int CNT_W = 6;

  // ****************************************
  // Register map and fields
  // ****************************************
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h4;
  localparam logic [3:0] REG_PAT = 4'h8;
  localparam logic [3:0] REG_WORD = 4'hC;
  localparam int CTRL_CRATE_LSB = 0;
  localparam int CTRL_X12 = 4;
  localparam int CTRL_CHAIN_LSB = 5;
  localparam int CTRL_LAST = 8;
  localparam int CTRL_START = 9;
  localparam int CTRL_RESET = 10;
  localparam int CTRL_W = 9;
  localparam logic [CTRL_W-1:0] CTRL_RST = 9'h000;

  // Output word as seen by the upstream interface
  typedef struct packed {
    logic [CHAIN_W-1:0] chain;
    logic [STN_W-1:0] station;
    logic flag;
    logic [8:0] raw;
  } crhr_word_s;
endpackage

// [rtl/crhr_prio_enc.sv]
/*
 * Lowest-set-bit priority encoder.
 * Purely combinational; the caller registers its result.
 */
`timescale 1ns/1ps
`default_nettype none
module crhr_prio_enc #(
  parameter int W = 22,
  parameter int IW = 5
) (
  // Pattern in
  input wire logic [W-1:0] pat,
  // Encoded result
  output logic [IW-1:0] idx,
  output logic any
);
  // Scan downward so the lowest set bit is the last to win
  always_comb begin
    idx = '0;
    any = 1'b0;
    for (int i = W - 1; i >= 0; i--) begin
      if (pat[i]) begin
        idx = IW'(i);
        any = 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// [dv/crhr_host_model.sv]
/*
 * Far-side read-out interface model: answers each offered word with the
 * done flag and keeps every word it took, in order.
 * Assumes the strobe and the word are registered outputs of the encoder.
 */
`timescale 1ns/1ps
`default_nettype none
module crhr_host_model (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Handshake
  input wire logic strobe,
  input wire crhr_pkg::crhr_word_s word,
  input wire logic [7:0] delay,
  input wire logic [7:0] hold,
  output logic done
);
  // ****************************************
  // Answer logic
  // ****************************************
  crhr_pkg::crhr_word_s got [$];
  logic [7:0] cnt;

  // Wait, raise done, keep it for the chosen length and until strobe drops
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      done <= 1'b0;
      cnt <= 8'h00;
    end else if (!done) begin
      if (strobe && cnt == delay) begin
        done <= 1'b1;
        got.push_back(word);
        cnt <= 8'h00;
      end else if (strobe) begin
        cnt <= cnt + 8'h01;
      end else begin
        cnt <= 8'h00;
      end
    end else if (cnt < hold || strobe) begin
      cnt <= cnt + 8'h01;
    end else begin
      done <= 1'b0;
      cnt <= 8'h00;
    end
  end
endmodule
`default_nettype wire

// [dv/test_crate_hit_readout_encoder.sv]
/*
 * Self-checking bench of the crate read-out encoder with station models.
 * Assumes crhr_encoder and crhr_host_model are compiled beforehand.
 */
`timescale 1ns/1ps
`default_nettype none
module test_crate_hit_readout_encoder;
  // ****************************************
  // Signals and models
  // ****************************************
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic cmd_in = 1'b0;
  logic ext_start = 1'b0;
  logic ext_rst = 1'b0;
  logic [7:0] delay = 8'h00;
  logic [7:0] hold = 8'h14;
  logic [21:0] hit = 22'h0;
  logic [15:0] mdata = 16'h0;
  logic mflag = 1'b0;
  logic [31:0] rdata;
  logic done, cmd_out, eor, strobe, busy, warn, mrst;
  logic [21:0] read_n;
  crhr_pkg::crhr_word_s word;
  logic [15:0] st_dat [22];
  logic [21:0] st_flg = 22'h0;
  int num_errors = 0;
  int n_tests = 0;
  int fwd = 0;
  int ends = 0;
  int sel;

  crhr_encoder i_dut (.CLK(clk), .NRST(nrst), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .READ_CMD_IN(cmd_in),
    .EXT_START(ext_start), .EXT_RESET(ext_rst),
    .TRANSFER_DONE_FLAG(done), .READ_CMD_OUT(cmd_out),
    .END_OF_READOUT(eor), .WORD_READY_STROBE(strobe), .WORD_OUT(word),
    .BUSY(busy), .CRATE12_WARN(warn), .MODULE_HIT_ANY(hit),
    .MODULE_DATA(mdata), .MODULE_FLAG(mflag), .MODULE_READ_N(read_n),
    .MODULE_RESET(mrst));
  crhr_host_model i_host (.clk(clk), .nrst(nrst), .strobe(strobe),
    .word(word), .delay(delay), .hold(hold), .done(done));

  // Clock
  initial begin
    forever #20 clk = ~clk;
  end

  // Stations: latches, hit-any, select low, idle bus toggles
  always @(posedge clk) begin
    if (mrst) st_dat = '{default: 16'h0};
    sel = -1;
    for (int i = 0; i < 22; i++) if (!read_n[i]) sel = i;
    mdata <= (sel >= 0) ? st_dat[sel] : ~mdata;
    mflag <= (sel >= 0) ? st_flg[sel] : ~mflag;
    // Hit-any from latches or flag switch
    for (int i = 0; i < 22; i++) hit[i] <= |st_dat[i] | st_flg[i];
    if (cmd_out) fwd <= fwd + 1;
    if (eor) ends <= ends + 1;
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  // Start a crate read-out, wait for its end, compare every word
  task automatic readout(input logic [3:0] cr, input logic x12,
    input logic [2:0] ch, input logic last, input int how);
    crhr_pkg::crhr_word_s e [$];
    crhr_pkg::crhr_word_s w;
    logic [21:0] m;
    logic [31:0] cfg;
    logic [31:0] d;
    int base, n0, cyc, f0, e0;
    base = (x12 && cr == 4'h0) ? 12 : int'(cr);
    for (int i = 0; i < 22; i++) for (int b = 0; b < 17; b++)
      if (b < 16 ? st_dat[i][b] : st_flg[i]) begin
        w.chain = ch;
        w.station = 9'(i + base * 22);
        w.flag = (b == 16);
        w.raw = {5'(i), 4'(b)};
        e.push_back(w);
      end
    f0 = fwd;
    e0 = ends;
    n0 = i_host.got.size();
    cfg = {23'h0, last, ch, x12, cr};
    wr_reg(crhr_pkg::REG_CTRL, cfg);
    if (how == 0) wr_reg(crhr_pkg::REG_CTRL, cfg | 32'h200);
    @(posedge clk);
    if (how == 1) ext_start <= 1'b1;
    if (how == 2) cmd_in <= 1'b1;
    repeat (4) @(posedge clk);
    ext_start <= 1'b0;
    cmd_in <= 1'b0;
    // Edges already gone by since the start was taken
    cyc = (how == 0) ? 6 : 2;
    while (fwd == f0 && ends == e0 && cyc < 9000) begin
      @(posedge clk);
      cyc++;
    end
    chk(32'(fwd - f0), {31'h0, !last});
    chk(32'(ends - e0), {31'h0, last});
    chk(32'(i_host.got.size() - n0), 32'(e.size()));
    for (int k = 0; k < e.size() && n0 + k < i_host.got.size(); k++) begin
      m = e[k].flag ? 22'h3FFE00 : 22'h3FFFFF;
      chk(32'(i_host.got[n0 + k] & m),
        32'(e[k] & m));
    end
    chk(32'(cyc >= crhr_pkg::OVH_CYC + e.size() * crhr_pkg::MIN_XFER_CYC),
      32'h1);
    chk({31'h0, warn}, {31'h0, x12});
    rd_reg(crhr_pkg::REG_STAT, d);
    chk(d, {30'h0, x12, 1'b0});
    if (e.size() > 0) begin
      rd_reg(crhr_pkg::REG_WORD, d);
      m = e[e.size() - 1].flag ? 22'h3FFE00 : 22'h3FFFFF;
      chk(d & 32'(m), 32'(e[e.size() - 1] & m));
    end
  endtask

  task automatic t_reset();
    logic [31:0] d;
    chk({10'h0, read_n}, 32'h3FFFFF);
    chk({30'h0, strobe, busy}, 32'h0);
    rd_reg(crhr_pkg::REG_CTRL, d);
    chk(d, 32'h0);
    rd_reg(4'h2, d);
    chk(d, 32'h0);
  endtask

  task automatic t_empty();
    st_dat = '{default: 16'h0};
    st_flg = 22'h0;
    repeat (3) @(posedge clk);
    readout(4'h1, 1'b0, 3'h2, 1'b0, 0);
  endtask

  task automatic t_main();
    st_dat[0] = 16'h8001;
    st_dat[5] = 16'h0006;
    st_dat[21] = 16'h4000;
    st_flg = 22'h000020;
    delay <= 8'h00;
    hold <= 8'h0F;
    repeat (3) @(posedge clk);
    readout(4'h3, 1'b0, 3'h5, 1'b1, 1);
  endtask

  task automatic t_crate12();
    st_dat = '{default: 16'h0};
    st_flg = 22'h0;
    st_dat[2] = 16'h0010;
    delay <= 8'h05;
    hold <= 8'h1E;
    repeat (3) @(posedge clk);
    readout(4'h0, 1'b1, 3'h7, 1'b0, 2);
    readout(4'hA, 1'b1, 3'h0, 1'b0, 0);
  endtask

  task automatic t_abort();
    int n;
    for (int s = 0; s < 2; s++) begin
      st_dat[3] = 16'hFFFF;
      repeat (3) @(posedge clk);
      wr_reg(crhr_pkg::REG_CTRL, 32'h200);
      n = 0;
      while (!strobe && n < 200) begin
        @(posedge clk);
        n++;
      end
      chk({31'h0, busy}, 32'h1);
      if (s == 0) wr_reg(crhr_pkg::REG_CTRL, 32'h400);
      else ext_rst <= 1'b1;
      repeat (2) @(posedge clk);
      ext_rst <= 1'b0;
      repeat (6) @(posedge clk);
      chk({31'h0, busy}, 32'h0);
      chk({10'h0, hit}, 32'h0);
    end
  endtask

  task automatic complete_run();
    $display("Checks %0d, errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ****************************************
  // Sequence and watchdog
  // ****************************************
  initial begin
    st_dat = '{default: 16'h0};
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset();
    t_empty();
    t_main();
    t_crate12();
    t_abort();
    complete_run();
  end

  initial begin
    #2400000;
    num_errors++;
    complete_run();
  end
endmodule
`default_nettype wire
